// >>> rtl/bssj_pkg.sv
// Package with operation codes, carriers and constants of the bit-scan, swap and jump slice.
package bssj_pkg;
  localparam int BSSJ_WORD_W = 16;
  localparam int BSSJ_PC_W = 23;
  localparam int BSSJ_REG_AW = 4;
  localparam logic [15:0] BSSJ_SIGN_MASK = 16'h8000;
  localparam logic [15:0] BSSJ_NOP_WORD = 16'h0000;
  localparam logic [15:0] BSSJ_SCAN_NONE = 16'h0000;
  localparam logic [15:0] BSSJ_SIGN_NONE = 16'hFFF1;
  localparam logic [6:0] BSSJ_PC_HIGH_CLEAR = 7'h00;
  localparam logic [22:0] BSSJ_TARGET_MAX = 23'h7FFFFE;
  localparam logic [4:0] BSSJ_SCAN_LAST = 5'h10;
  localparam logic [4:0] BSSJ_SCAN_COUNT = 5'h10;

  typedef enum {
    BSSJ_OP_NONE,
    BSSJ_OP_SIGN_SCAN,
    BSSJ_OP_LEAD_SCAN,
    BSSJ_OP_TRAIL_SCAN,
    BSSJ_OP_SWAP,
    BSSJ_OP_JUMP_DIRECT,
    BSSJ_OP_JUMP_INDIRECT
  } bssj_op_t;

  typedef struct packed {
    logic valid;
    logic [3:0] op;
    logic [BSSJ_REG_AW-1:0] src_addr;
    logic [BSSJ_REG_AW-1:0] dst_addr;
    logic [BSSJ_PC_W-1:0] jump_target_literal;
  } bssj_cmd_t;

  typedef struct packed {
    logic wr_en;
    logic [BSSJ_REG_AW-1:0] wr_addr;
    logic [BSSJ_WORD_W-1:0] wr_data;
  } bssj_wr_t;
endpackage

// >>> rtl/bssj_regfile.sv
// Working register file with two registered read ports and two write ports.
`timescale 1ns/1ps
module bssj_regfile import bssj_pkg::*; #(
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [BSSJ_REG_AW-1:0] rd_a_addr_in,
  input wire logic [BSSJ_REG_AW-1:0] rd_b_addr_in,
  input wire bssj_wr_t wr_a_in,
  input wire bssj_wr_t wr_b_in,
  output logic [BSSJ_WORD_W-1:0] rd_a_data_out,
  output logic [BSSJ_WORD_W-1:0] rd_b_data_out
);
  typedef struct packed {
    logic [DEPTH-1:0][BSSJ_WORD_W-1:0] mem;
    logic [BSSJ_WORD_W-1:0] rd_a;
    logic [BSSJ_WORD_W-1:0] rd_b;
  } bssj_rf_state_t;

  bssj_rf_state_t state;
  bssj_rf_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.rd_a = state.mem[rd_a_addr_in];
    next_state.rd_b = state.mem[rd_b_addr_in];
    if (wr_a_in.wr_en) begin
      next_state.mem[wr_a_in.wr_addr] = wr_a_in.wr_data;
    end
    if (wr_b_in.wr_en) begin
      next_state.mem[wr_b_in.wr_addr] = wr_b_in.wr_data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_a_data_out = state.rd_a;
  assign rd_b_data_out = state.rd_b;
endmodule

// >>> rtl/bssj_core.sv
// Execution slice for bit scans, register swap and unconditional jumps.
`timescale 1ns/1ps
module bssj_core import bssj_pkg::*; #(
  parameter int REG_DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire bssj_cmd_t cmd_in,
  input wire bssj_wr_t ext_wr_in,
  input wire logic [BSSJ_REG_AW-1:0] peek_addr_in,
  output logic [BSSJ_WORD_W-1:0] peek_data_out,
  output logic busy_out,
  output logic done_out,
  output logic carry_out,
  output logic [BSSJ_PC_W-1:0] pc_out,
  output logic pc_load_out,
  output logic [BSSJ_WORD_W-1:0] instr_reg_out,
  output logic instr_flush_out
);
  // The slice walks idle, operand read, execute and, for a swap only, a second write cycle.
  typedef enum {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_SWAP2
  } bssj_st_t;

  // All state of the slice outside the register file lives in this one packed struct.
  typedef struct packed {
    bssj_st_t st;
    logic [3:0] op;
    logic [BSSJ_REG_AW-1:0] src;
    logic [BSSJ_REG_AW-1:0] dst;
    logic [BSSJ_PC_W-1:0] lit;
    logic [BSSJ_WORD_W-1:0] swap_hold;
    logic carry;
    logic [BSSJ_PC_W-1:0] pc;
    logic pc_load;
    logic [BSSJ_WORD_W-1:0] ir;
    logic flush;
    logic done;
  } bssj_state_t;

  bssj_state_t state;
  bssj_state_t next_state;
  bssj_wr_t wr_core;
  bssj_wr_t wr_peek_unused;
  logic [BSSJ_WORD_W-1:0] rd_a;
  logic [BSSJ_WORD_W-1:0] rd_b;
  logic [BSSJ_REG_AW-1:0] rd_a_addr;
  logic [BSSJ_REG_AW-1:0] rd_b_addr;

  // Position of first one from MSb, numbered 1 at MSb, 0 when absent.
  function automatic logic [4:0] lead_pos(input logic [15:0] w);
    logic [4:0] p;
    p = 5'h00;
    // Scanning upward lets the highest set bit win.
    for (int i = 0; i < BSSJ_WORD_W; i++) begin
      if (w[i]) begin
        p = 5'(BSSJ_WORD_W - i);
      end
    end
    return p;
  endfunction

  // Position of first one from LSb, numbered 1 at LSb, 0 when absent.
  function automatic logic [4:0] trail_pos(input logic [15:0] w);
    logic [4:0] p;
    p = 5'h00;
    // Scanning downward lets the lowest set bit win.
    for (int i = BSSJ_WORD_W - 1; i >= 0; i--) begin
      if (w[i]) begin
        p = 5'(i + 1);
      end
    end
    return p;
  endfunction

  // Sign-change result: bit 14 gives 0, bit 0 gives -14, none gives -15.
  function automatic logic [15:0] sign_scan(input logic [15:0] w);
    logic [15:0] r;
    logic sgn;
    logic found;
    r = BSSJ_SIGN_NONE;
    sgn = (w & BSSJ_SIGN_MASK) != 16'h0000;
    found = 1'b0;
    // The sign bit itself is never a candidate.
    for (int i = BSSJ_WORD_W - 2; i >= 0; i--) begin
      if (!found && (w[i] != sgn)) begin
        found = 1'b1;
        r = 16'(i - (BSSJ_WORD_W - 2));
      end
    end
    return r;
  endfunction

  // Port A follows the incoming command while idle so that the operand is registered early.
  assign rd_a_addr = (state.st == ST_IDLE) ? cmd_in.src_addr : state.src;
  // Port B serves the peek path while idle and fetches the old destination for a swap.
  assign rd_b_addr = (state.st == ST_IDLE) ? peek_addr_in : state.dst;
  assign wr_peek_unused = ext_wr_in;

  // External writes use port B, which the file applies last, so they win a clash with the core.
  bssj_regfile #(
    .DEPTH(REG_DEPTH)
  ) u_regfile (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .rd_a_addr_in(rd_a_addr),
    .rd_b_addr_in(rd_b_addr),
    .wr_a_in(wr_core),
    .wr_b_in(wr_peek_unused),
    .rd_a_data_out(rd_a),
    .rd_b_data_out(rd_b)
  );

  // Idle accepts a command, read lets the operands settle, execute writes the results.
  always_comb begin
    logic [4:0] pos;
    pos = 5'h00;
    next_state = state;
    next_state.pc_load = 1'b0;
    next_state.flush = 1'b0;
    next_state.done = 1'b0;
    wr_core = '0;
    case (state.st)
      ST_IDLE: begin
        // A command without an operation is ignored, so an empty decode slot costs nothing.
        if (cmd_in.valid && cmd_in.op != 4'(BSSJ_OP_NONE)) begin
          next_state.op = cmd_in.op;
          next_state.src = cmd_in.src_addr;
          next_state.dst = cmd_in.dst_addr;
          next_state.lit = cmd_in.jump_target_literal;
          next_state.st = ST_READ;
        end
      end
      // The read cycle gives the registered read ports time to present the operands.
      ST_READ: begin
        next_state.st = ST_EXEC;
      end
      ST_EXEC: begin
        next_state.st = ST_IDLE;
        next_state.done = 1'b1;
        case (state.op)
          // Scan results land with done, and carry is set only when nothing was found.
          4'(BSSJ_OP_SIGN_SCAN): begin
            wr_core = '{wr_en: 1'b1, wr_addr: state.dst, wr_data: sign_scan(rd_a)};
            next_state.carry = (sign_scan(rd_a) == BSSJ_SIGN_NONE);
          end
          4'(BSSJ_OP_LEAD_SCAN): begin
            pos = lead_pos(rd_a);
            wr_core = '{wr_en: 1'b1, wr_addr: state.dst, wr_data: {11'h000, pos}};
            next_state.carry = (pos == 5'h00);
          end
          4'(BSSJ_OP_TRAIL_SCAN): begin
            pos = trail_pos(rd_a);
            wr_core = '{wr_en: 1'b1, wr_addr: state.dst, wr_data: {11'h000, pos}};
            next_state.carry = (pos == 5'h00);
          end
          // With one core write port the swap writes the destination now and the source next cycle.
          4'(BSSJ_OP_SWAP): begin
            wr_core = '{wr_en: 1'b1, wr_addr: state.dst, wr_data: rd_a};
            next_state.swap_hold = rd_b;
            next_state.st = ST_SWAP2;
            next_state.done = 1'b0;
          end
          // Jumps discard the fetched word by loading a no-operation into the instruction register.
          4'(BSSJ_OP_JUMP_DIRECT): begin
            next_state.pc = {state.lit[BSSJ_PC_W-1:1], 1'b0};
            next_state.pc_load = 1'b1;
            next_state.ir = BSSJ_NOP_WORD;
            next_state.flush = 1'b1;
          end
          4'(BSSJ_OP_JUMP_INDIRECT): begin
            next_state.pc = {BSSJ_PC_HIGH_CLEAR, rd_a[BSSJ_WORD_W-1:1], 1'b0};
            next_state.pc_load = 1'b1;
            next_state.ir = BSSJ_NOP_WORD;
            next_state.flush = 1'b1;
          end
          default: begin
          end
        endcase
      end
      // The old destination value held from execute now lands in the source register.
      ST_SWAP2: begin
        wr_core = '{wr_en: 1'b1, wr_addr: state.src, wr_data: state.swap_hold};
        next_state.st = ST_IDLE;
        next_state.done = 1'b1;
      end
      default: begin
        next_state.st = ST_IDLE;
      end
    endcase
  end

  // Synchronous reset returns the slice to idle with flags and program counter cleared.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= '{st: ST_IDLE, default: '0};
    end else begin
      state <= next_state;
    end
  end

  // Busy decodes the state; every data output comes straight from a register.
  assign peek_data_out = rd_b;
  assign busy_out = (state.st != ST_IDLE);
  assign done_out = state.done;
  assign carry_out = state.carry;
  assign pc_out = state.pc;
  assign pc_load_out = state.pc_load;
  assign instr_reg_out = state.ir;
  assign instr_flush_out = state.flush;
endmodule

// >>> verif/bssj_chk_assertions.sv
// Checker of the scan and jump slice ports.
`timescale 1ns/1ps
module bssj_chk import bssj_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire bssj_cmd_t cmd_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [22:0] pc_out,
  input wire logic pc_load_out,
  input wire logic [15:0] instr_reg_out,
  input wire logic instr_flush_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire tk = !busy_out && cmd_in.valid && cmd_in.op != 4'h0;
  wire [21:0] lit = cmd_in.jump_target_literal[22:1];
  scan_late_a: assert property (tk && cmd_in.op inside {1, 2, 3} |=> !done_out[*2] ##1 done_out)
    else $error("scan done late");
  jump_late_a: assert property (tk && cmd_in.op inside {5, 6} |-> ##3 done_out && pc_load_out)
    else $error("jump done late");
  busy_take_a: assert property (tk |=> busy_out)
    else $error("busy missing");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done too long");
  pc_even_a: assert property (pc_load_out |-> !pc_out[0])
    else $error("pc odd");
  flush_nop_a: assert property (pc_load_out |-> instr_flush_out && instr_reg_out == 16'h0000)
    else $error("no flush");
  direct_pc_a: assert property (tk && cmd_in.op == 4'h5 |-> ##3 pc_out[22:1] == $past(lit, 3))
    else $error("direct pc wrong");
  indir_high_a: assert property (tk && cmd_in.op == 4'h6 |-> ##3 pc_out[22:16] == 7'h00)
    else $error("pc high set");
  cover property (tk && cmd_in.op == 4'h1);
  cover property (tk && cmd_in.op == 4'h6);
  cover property (tk && cmd_in.op == 4'h4);
  cover property (pc_load_out);
endmodule
bind bssj_core bssj_chk i_chk(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_in(cmd_in), .busy_out(busy_out),
  .done_out(done_out), .pc_out(pc_out), .pc_load_out(pc_load_out), .instr_reg_out(instr_reg_out),
  .instr_flush_out(instr_flush_out));

// >>> verif/bssj_dec_model.sv
// Decoder model that hands commands to the slice.
`timescale 1ns/1ps
module bssj_dec_model import bssj_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic done_in,
  output bssj_cmd_t cmd_out
);
  initial cmd_out = '0;
  // Fields are scrambled once valid drops so stale values cannot be reused.
  task automatic issue(input logic [3:0] op, input logic [3:0] s, input logic [3:0] d,
    input logic [22:0] lt, output int lat);
    @(negedge clk_sys_in);
    cmd_out = '{1'b1, op, s, d, lt};
    lat = 0;
    do begin
      @(negedge clk_sys_in);
      cmd_out = {1'b0, ~cmd_out[34:0]};
      lat++;
    end while (done_in !== 1'b1 && lat < 20);
  endtask
endmodule

// >>> verif/bit_scan_swap_jump_datapath_test.sv
// Self-checking bench of the scan and jump slice.
`timescale 1ns/1ps
module bit_scan_swap_jump_datapath_test import bssj_pkg::*; ;
  logic clk_sys_in = 0;
  logic rst_in = 1;
  bssj_cmd_t cmd;
  bssj_wr_t wr = '0;
  logic [3:0] pa = '0;
  logic [15:0] pd, ir;
  logic busy, done, carry, pcl, fl;
  logic [22:0] pc;
  int errors = 0, cmp_count = 0, cyc = 0, lat;
  always #5 clk_sys_in = ~clk_sys_in;
  bssj_core i_dut(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_in(cmd), .ext_wr_in(wr), .peek_addr_in(pa),
    .peek_data_out(pd), .busy_out(busy), .done_out(done), .carry_out(carry), .pc_out(pc),
    .pc_load_out(pcl), .instr_reg_out(ir), .instr_flush_out(fl));
  bssj_dec_model i_dec(.clk_sys_in(clk_sys_in), .done_in(done), .cmd_out(cmd));
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [22:0] s, input logic [22:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic put(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk_sys_in);
    wr = '{1'b1, a, d};
    @(negedge clk_sys_in);
    wr = '{1'b0, ~a, ~d};
  endtask
  // Carry in the top bit, result word below it.
  function automatic logic [16:0] exp_scan(input int op, input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      if (op == 1 && i < 15 && w[i] != w[15]) return {1'b0, 16'(i - 14)};
      if (op == 2 && w[i]) return {1'b0, 16'(16 - i)};
      if (op == 3 && w[15 - i]) return {1'b0, 16'(16 - i)};
    end
    return (op == 1) ? 17'h1FFF1 : 17'h10000;
  endfunction
  task automatic t_scans();
    logic [15:0] w [8] = '{16'h55FF, 16'hFFFF, 16'hFF0A, 16'h0000, 16'h0001, 16'h8000, 16'h4000, 16'h000A};
    logic [16:0] e;
    for (int op = 1; op <= 3; op++) begin
      foreach (w[k]) begin
        put(4'h1, w[k]);
        i_dec.issue(4'(op), 4'h1, 4'h2, 23'h0, lat);
        e = exp_scan(op, w[k]);
        chk("scan latency", 23'(lat), 23'h3);
        chk("scan carry", 23'(carry), 23'(e[16]));
        @(negedge clk_sys_in);
        pa = 4'h2;
        repeat (2) @(negedge clk_sys_in);
        chk("scan result", 23'(pd), 23'(e[15:0]));
      end
    end
    $display("scan test done");
  endtask
  task automatic t_swap();
    put(4'h3, 16'hA3A3);
    put(4'h4, 16'h55FF);
    put(4'h6, 16'h0000);
    i_dec.issue(4'h3, 4'h6, 4'h7, 23'h0, lat);
    chk("carry before swap", 23'(carry), 23'h1);
    i_dec.issue(4'h4, 4'h3, 4'h4, 23'h0, lat);
    chk("swap latency", 23'(lat), 23'h4);
    chk("swap carry", 23'(carry), 23'h1);
    @(negedge clk_sys_in);
    pa = 4'h3;
    repeat (2) @(negedge clk_sys_in);
    chk("swap first", 23'(pd), 23'h0055FF);
    pa = 4'h4;
    repeat (2) @(negedge clk_sys_in);
    chk("swap second", 23'(pd), 23'h00A3A3);
    i_dec.issue(4'h4, 4'h4, 4'h4, 23'h0, lat);
    repeat (3) @(negedge clk_sys_in);
    chk("swap self", 23'(pd), 23'h00A3A3);
    $display("swap test done");
  endtask
  task automatic t_jump();
    i_dec.issue(4'h5, 4'h0, 4'h0, 23'h7FFFFF, lat);
    chk("direct pc", pc, 23'h7FFFFE);
    chk("direct flush", 23'({pcl, fl, ir}), 23'h30000);
    put(4'h5, 16'h7845);
    i_dec.issue(4'h6, 4'h5, 4'h0, 23'h0, lat);
    chk("indirect pc", pc, 23'h007844);
    chk("indirect flush", 23'({pcl, fl, ir}), 23'h30000);
    $display("jump test done");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 0;
    t_scans();
    t_swap();
    t_jump();
    end_sim();
  end
endmodule
